// *** pkg/rbm_regs.svh ***
// Contract
// RULE1 - Both blocks share one external memory
// RULE2 - Each processor reads its block index bit
// RULE3 - Host holds reset low about 20 ms; the testbench holds it 10 clock cycles
// RULE4 - Straps sampled at reset release set config
// RULE5 - Board ties straps through 10K resistors
// RULE6 - Refresh strap high runs SDRAM init cycles
// RULE7 - DSP engines idle after reset release
// RULE8 - Refresh low: start 0100H, external ROM
// RULE9 - Refresh high: start 0000H, bootstrap ROM
// RULE10 - Bootstrap loads 256 words to 0100H-01FFH
// RULE11 - After load, execution moves to 0100H
// RULE12 - Power-down low floats pins, stops clocks
// RULE13 - Exit power-down: raise pin, then reset
// RULE14 - Byte address bit 27 selects page
// RULE15 - RAM in low page needs bootstrap straps
// RULE16 - Standalone strap table for page types
// RULE17 - Bootstrap strap table for page types
// RULE18 - DRAM access uses RAS/CAS, muxed rows
// RULE19 - SRAM/ROM access uses page selects
// RULE20 - Straps held until next reset
// RULE21 - Boot words stored in arrival order
`ifndef RBM_REGS_SVH
`define RBM_REGS_SVH

`define RBM_ADDR_CTRL      12'h000
`define RBM_ADDR_STATUS    12'h004
`define RBM_CTRL_DSP_RUN   0
`define RBM_CTRL_HPT_LSB   1
`define RBM_CTRL_RESET     3'h0
`define RBM_ST_STRAP_LSB   0
`define RBM_ST_STATE_LSB   3
`define RBM_ST_BOOTDONE    6
`define RBM_ST_SDDONE      7
`define RBM_ST_LOTYPE_LSB  8
`define RBM_ST_HITYPE_LSB  10

`define RBM_HIGH_PAGE_BIT  27
`define RBM_VEC_EXT        16'h0100
`define RBM_VEC_BOOT       16'h0000
`define RBM_BOOT_BASE      16'h0100
`define RBM_BOOT_WORDS     9'h100
`define RBM_ACC_CYC        3'h6
`define RBM_ROW_CYC        3'h3
`define RBM_SDINIT_CYC     8'h10

`endif

// *** pkg/rbm_pkg.sv ***
package rbm_pkg;
  typedef enum logic [1:0] {
    RBM_MT_ROM   = 2'b00,
    RBM_MT_SRAM  = 2'b01,
    RBM_MT_DRAM  = 2'b10,
    RBM_MT_SDRAM = 2'b11
  } rbm_mem_e;

  typedef enum logic [2:0] {
    RBM_ST_CAPTURE = 3'b000,
    RBM_ST_SDINIT  = 3'b001,
    RBM_ST_BOOT    = 3'b010,
    RBM_ST_RUN     = 3'b011,
    RBM_ST_PDOWN   = 3'b100
  } rbm_state_e;
endpackage : rbm_pkg

// *** hdl/rbm_boot_loader.sv ***
`timescale 1ns/1ps
`include "rbm_regs.svh"
module rbm_boot_loader import rbm_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        loadEn,
  input  wire logic        burstValid,
  input  wire logic [15:0] burstData,
  output logic             burstReady,
  output logic             wrReq,
  output logic [27:0]      wrAddr,
  output logic [15:0]      wrData,
  input  wire logic        wrAck,
  output logic             loadDone
);
  logic [8:0]  wordCnt;
  logic [8:0]  next_wordCnt;
  logic        holding;
  logic        next_holding;
  logic [15:0] next_wrData;
  logic [15:0] wordAddr;

  assign loadDone   = (wordCnt == `RBM_BOOT_WORDS);
  assign burstReady = loadEn && !holding && !loadDone;
  assign wrReq      = holding;
  assign wordAddr   = `RBM_BOOT_BASE + {8'h00, wordCnt[7:0]}; // RULE10 RULE21
  assign wrAddr     = {11'h000, wordAddr, 1'b0};

  always_comb begin
    next_wordCnt = wordCnt;
    next_holding = holding;
    next_wrData  = wrData;
    if (burstValid && burstReady) begin // RULE10
      next_holding = 1'b1;
      next_wrData  = burstData;
    end else if (holding && wrAck) begin
      next_holding = 1'b0;
      next_wordCnt = wordCnt + 9'h001; // RULE21
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wordCnt <= 9'h000;
      holding <= 1'b0;
      wrData  <= 16'h0000;
    end else begin
      wordCnt <= next_wordCnt;
      holding <= next_holding;
      wrData  <= next_wrData;
    end
  end

  a_boot_addr_order: assert property (@(posedge clk) disable iff (!rst_n) // RULE21
    wrAck && wrReq && (wordCnt[7:0] != 8'hff) |=> wrAddr == $past(wrAddr) + 28'h000_0002)
    else $error("Boot word address did not advance by one word");
  a_boot_range: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    wrReq |-> wrAddr >= 28'h000_0200 && wrAddr <= 28'h000_03fe)
    else $error("Boot write outside 0100H-01FFH");
  a_boot_full_stop: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    loadDone |-> !burstReady && !wrReq)
    else $error("Loader accepts data after 256 words");
  c_boot_done: cover property (@(posedge clk) disable iff (!rst_n) $rose(loadDone));
endmodule : rbm_boot_loader

// *** hdl/rbm_top.sv ***
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "rbm_regs.svh"
module rbm_top import rbm_pkg::*; (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        refreshStrapPin,
  input  wire logic        rowStrobeStrapPin,
  input  wire logic        colStrobeStrapPin,
  input  wire logic        powerDownPin_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        burstValid0,
  input  wire logic [15:0] burstData0,
  output logic             burstReady0,
  input  wire logic        burstValid1,
  input  wire logic [15:0] burstData1,
  output logic             burstReady1,
  input  wire logic        cpuReq0,
  input  wire logic [27:0] cpuAddr0,
  output logic             cpuAck0,
  input  wire logic        cpuReq1,
  input  wire logic [27:0] cpuAddr1,
  output logic             cpuAck1,
  output logic             cpuRun,
  output logic [15:0]      cpuStartAddr,
  output logic             bootRomSel,
  output logic             processorIndexBit0,
  output logic             processorIndexBit1,
  output logic             dspIdle,
  output logic             oscStop,
  output logic [26:0]      memoryAddressPins,
  output logic             lowPageSelect_n,
  output logic             highPageSelect_n,
  output logic             ras_n,
  output logic             cas_n,
  output logic             memWe_n,
  output logic [15:0]      memDataOut,
  output logic             pinOe_n,
  output logic             memDataOe_n
);
  logic [2:0]  strapMeta;
  logic [2:0]  strapSync;
  logic        pdMeta;
  logic        pdSync;
  rbm_state_e  state;
  rbm_state_e  next_state;
  logic [2:0]  strap;
  logic [2:0]  next_strap;
  logic [7:0]  sdCnt;
  logic [7:0]  next_sdCnt;
  logic        bootDone;
  logic        next_bootDone;
  logic        sdDone;
  logic        next_sdDone;
  logic [2:0]  ctrl;
  logic [2:0]  next_ctrl;
  logic [31:0] next_prdata;
  rbm_mem_e    loType;
  rbm_mem_e    hiType;
  logic        accBusy;
  logic        next_accBusy;
  logic [2:0]  accCnt;
  logic [2:0]  next_accCnt;
  logic [1:0]  accOwner;
  logic [1:0]  next_accOwner;
  logic [27:0] accAddr;
  logic [27:0] next_accAddr;
  logic        accWrite;
  logic        next_accWrite;
  logic        lastCpu;
  logic        next_lastCpu;
  logic        accDram;
  logic        colPhase;
  logic        accEnd;
  logic        ldEn;
  logic [1:0]  ldReq;
  logic [1:0]  ldAck;
  logic [1:0]  ldDone;
  logic [27:0] ldAddr0;
  logic [27:0] ldAddr1;
  logic [15:0] ldData0;
  logic [15:0] ldData1;
  logic [11:0] row_col_address;
  logic [26:0] next_memoryAddressPins;
  logic        next_lowSel_n;
  logic        next_highSel_n;
  logic        next_ras_n;
  logic        next_cas_n;
  logic        next_memWe_n;
  logic [15:0] next_memDataOut;
  logic [15:0] next_cpuStartAddr;

  // Strap and power-down pins cross into the clock domain
  always_ff @(posedge clk) begin
    strapMeta <= {refreshStrapPin, rowStrobeStrapPin, colStrobeStrapPin};
    strapSync <= strapMeta;
    pdMeta    <= powerDownPin_n;
    pdSync    <= pdMeta;
  end

  // Page type decode from held straps; high type from ctrl when straps are 011
  always_comb begin
    if (!strap[2]) begin
      loType = RBM_MT_ROM; // RULE16
      case (strap[1:0])
        2'b00:   hiType = RBM_MT_SRAM;
        2'b01:   hiType = RBM_MT_DRAM;
        2'b10:   hiType = RBM_MT_SDRAM;
        default: hiType = rbm_mem_e'(ctrl[`RBM_CTRL_HPT_LSB +: 2]);
      endcase
    end else begin
      hiType = RBM_MT_ROM; // RULE17
      if (strap[1])
        loType = RBM_MT_SDRAM;
      else if (strap[0])
        loType = RBM_MT_DRAM;
      else
        loType = RBM_MT_SRAM;
    end
  end

  // Top-level sequence
  always_comb begin
    next_state    = state;
    next_strap    = strap;
    next_sdCnt    = sdCnt;
    next_bootDone = bootDone;
    next_sdDone   = sdDone;
    case (state)
      RBM_ST_CAPTURE: begin
        next_strap = strapSync; // RULE4 RULE20
        next_state = strapSync[2] ? RBM_ST_SDINIT : RBM_ST_RUN; // RULE8
      end
      RBM_ST_SDINIT: begin
        next_sdCnt = sdCnt + 8'h01; // RULE6
        if (sdCnt == `RBM_SDINIT_CYC - 8'h01) begin
          next_sdDone = 1'b1;
          next_state  = RBM_ST_BOOT; // RULE9
        end
      end
      RBM_ST_BOOT: begin
        if (&ldDone && !accBusy) begin
          next_bootDone = 1'b1;
          next_state    = RBM_ST_RUN; // RULE11
        end
      end
      RBM_ST_RUN:   next_state = RBM_ST_RUN;
      RBM_ST_PDOWN: next_state = RBM_ST_PDOWN; // RULE13
      default:      next_state = RBM_ST_CAPTURE;
    endcase
    if (!pdSync && state != RBM_ST_CAPTURE)
      next_state = RBM_ST_PDOWN; // RULE12
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state    <= RBM_ST_CAPTURE;
      strap    <= 3'h0;
      sdCnt    <= 8'h00;
      bootDone <= 1'b0;
      sdDone   <= 1'b0;
    end else begin
      state    <= next_state;
      strap    <= next_strap;
      sdCnt    <= next_sdCnt;
      bootDone <= next_bootDone;
      sdDone   <= next_sdDone;
    end
  end

  assign ldEn = (state == RBM_ST_BOOT);

  rbm_boot_loader u_loader0 (
    .clk        (clk),
    .rst_n      (rst_n),
    .loadEn     (ldEn),
    .burstValid (burstValid0),
    .burstData  (burstData0),
    .burstReady (burstReady0),
    .wrReq      (ldReq[0]),
    .wrAddr     (ldAddr0),
    .wrData     (ldData0),
    .wrAck      (ldAck[0]),
    .loadDone   (ldDone[0])
  );

  rbm_boot_loader u_loader1 (
    .clk        (clk),
    .rst_n      (rst_n),
    .loadEn     (ldEn),
    .burstValid (burstValid1),
    .burstData  (burstData1),
    .burstReady (burstReady1),
    .wrReq      (ldReq[1]),
    .wrAddr     (ldAddr1),
    .wrData     (ldData1),
    .wrAck      (ldAck[1]),
    .loadDone   (ldDone[1])
  );

  // Shared memory arbiter: owner 0/1 loaders, 2/3 processors
  assign accEnd   = accBusy && (accCnt == `RBM_ACC_CYC - 3'h1);
  assign ldAck[0] = accEnd && (accOwner == 2'd0);
  assign ldAck[1] = accEnd && (accOwner == 2'd1);
  assign cpuAck0  = accEnd && (accOwner == 2'd2); // RULE1
  assign cpuAck1  = accEnd && (accOwner == 2'd3);

  always_comb begin
    next_accBusy  = accBusy;
    next_accCnt   = accCnt;
    next_accOwner = accOwner;
    next_accAddr  = accAddr;
    next_accWrite = accWrite;
    next_lastCpu  = lastCpu;
    next_memDataOut = memDataOut;
    if (state == RBM_ST_PDOWN) begin
      next_accBusy = 1'b0;
      next_accCnt  = 3'h0;
    end else if (accBusy) begin
      next_accBusy = !accEnd;
      next_accCnt  = accEnd ? 3'h0 : accCnt + 3'h1;
    end else if (state == RBM_ST_BOOT && |ldReq) begin
      next_accBusy    = 1'b1;
      next_accWrite   = 1'b1;
      next_accOwner   = ldReq[0] ? 2'd0 : 2'd1;
      next_accAddr    = ldReq[0] ? ldAddr0 : ldAddr1;
      next_memDataOut = ldReq[0] ? ldData0 : ldData1;
    end else if (state == RBM_ST_RUN && (cpuReq0 || cpuReq1)) begin
      next_accBusy  = 1'b1; // RULE1
      next_accWrite = 1'b0;
      if (cpuReq0 && (!cpuReq1 || lastCpu)) begin
        next_accOwner = 2'd2;
        next_accAddr  = cpuAddr0;
        next_lastCpu  = 1'b0;
      end else begin
        next_accOwner = 2'd3;
        next_accAddr  = cpuAddr1;
        next_lastCpu  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accBusy    <= 1'b0;
      accCnt     <= 3'h0;
      accOwner   <= 2'd0;
      accAddr    <= 28'h000_0000;
      accWrite   <= 1'b0;
      lastCpu    <= 1'b0;
      memDataOut <= 16'h0000;
    end else begin
      accBusy    <= next_accBusy;
      accCnt     <= next_accCnt;
      accOwner   <= next_accOwner;
      accAddr    <= next_accAddr;
      accWrite   <= next_accWrite;
      lastCpu    <= next_lastCpu;
      memDataOut <= next_memDataOut;
    end
  end

  // Pin drive for the current access
  assign accDram  = accAddr[`RBM_HIGH_PAGE_BIT] ? (hiType[1]) : (loType[1]); // RULE14
  assign colPhase = (accCnt >= `RBM_ROW_CYC);
  assign row_col_address      = colPhase ? accAddr[12:1] : accAddr[24:13];

  always_comb begin
    next_memoryAddressPins = 27'h000_0000;
    next_ras_n     = 1'b1;
    next_cas_n     = 1'b1;
    next_lowSel_n  = 1'b1;
    next_highSel_n = 1'b1;
    next_memWe_n   = 1'b1;
    if (state == RBM_ST_SDINIT) begin
      next_ras_n = sdCnt[0]; // RULE6
      next_cas_n = sdCnt[0];
    end else if (accBusy) begin
      if (accDram) begin
        next_ras_n = 1'b0; // RULE18
        next_cas_n = !colPhase;
        next_memoryAddressPins[8:0] = row_col_address[8:0];
        next_memoryAddressPins[18]  = row_col_address[9];
        next_memoryAddressPins[20]  = row_col_address[10];
        next_memoryAddressPins[22]  = row_col_address[11];
      end else begin
        next_memoryAddressPins = accAddr[27:1]; // RULE19
        next_lowSel_n  = accAddr[`RBM_HIGH_PAGE_BIT]; // RULE14 RULE8
        next_highSel_n = !accAddr[`RBM_HIGH_PAGE_BIT];
      end
      next_memWe_n = !(accWrite && colPhase);
    end
    next_cpuStartAddr = (state == RBM_ST_RUN) ? `RBM_VEC_EXT : `RBM_VEC_BOOT; // RULE9 RULE11
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      memoryAddressPins <= 27'h000_0000;
      ras_n             <= 1'b1;
      cas_n             <= 1'b1;
      lowPageSelect_n   <= 1'b1;
      highPageSelect_n  <= 1'b1;
      memWe_n           <= 1'b1;
      pinOe_n           <= 1'b0;
      memDataOe_n       <= 1'b1;
      oscStop           <= 1'b0;
      cpuStartAddr      <= `RBM_VEC_BOOT;
      cpuRun            <= 1'b0;
      bootRomSel        <= 1'b0;
      dspIdle           <= 1'b1;
    end else begin
      memoryAddressPins <= next_memoryAddressPins;
      ras_n             <= next_ras_n;
      cas_n             <= next_cas_n;
      lowPageSelect_n   <= next_lowSel_n;
      highPageSelect_n  <= next_highSel_n;
      memWe_n           <= next_memWe_n;
      pinOe_n           <= (next_state == RBM_ST_PDOWN); // RULE12
      memDataOe_n       <= (next_state == RBM_ST_PDOWN) || !(next_accBusy && next_accWrite);
      oscStop           <= (next_state == RBM_ST_PDOWN); // RULE12
      cpuStartAddr      <= next_cpuStartAddr;
      cpuRun            <= (next_state == RBM_ST_BOOT) || (next_state == RBM_ST_RUN);
      bootRomSel        <= (next_state == RBM_ST_BOOT); // RULE9
      dspIdle           <= !(next_state == RBM_ST_RUN && next_ctrl[`RBM_CTRL_DSP_RUN]); // RULE7
    end
  end

  assign processorIndexBit0 = 1'b0; // RULE2
  assign processorIndexBit1 = 1'b1; // RULE2

  // APB slave, zero wait states
  assign pready  = 1'b1;
  assign pslverr = psel && penable && (paddr != `RBM_ADDR_CTRL) && (paddr != `RBM_ADDR_STATUS);

  always_comb begin
    next_ctrl   = ctrl;
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      if (paddr == `RBM_ADDR_CTRL)
        next_prdata[2:0] = ctrl;
      else if (paddr == `RBM_ADDR_STATUS) begin
        next_prdata[`RBM_ST_STRAP_LSB +: 3] = strap;
        next_prdata[`RBM_ST_STATE_LSB +: 3] = state;
        next_prdata[`RBM_ST_BOOTDONE]       = bootDone;
        next_prdata[`RBM_ST_SDDONE]         = sdDone;
        next_prdata[`RBM_ST_LOTYPE_LSB +: 2] = loType;
        next_prdata[`RBM_ST_HITYPE_LSB +: 2] = hiType;
      end
    end
    if (psel && penable && pwrite && paddr == `RBM_ADDR_CTRL)
      next_ctrl = pwdata[2:0];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl   <= `RBM_CTRL_RESET;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl   <= next_ctrl;
      prdata <= next_prdata;
    end
  end

  a_strap_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE20
    $past(state) != RBM_ST_CAPTURE |-> $stable(strap))
    else $error("Strap configuration changed after capture");
  a_sdinit_entry: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    state == RBM_ST_SDINIT |-> strap[2])
    else $error("SDRAM init without refresh strap");
  a_boot_vector: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    state == RBM_ST_BOOT ##1 state == RBM_ST_BOOT |-> cpuStartAddr == 16'h0000 && bootRomSel)
    else $error("Bootstrap vector not 0000H");
  a_run_vector: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    $past(state) == RBM_ST_RUN && state == RBM_ST_RUN |-> cpuStartAddr == 16'h0100 && cpuRun)
    else $error("Run vector not 0100H");
  a_dsp_idle: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    state != RBM_ST_RUN |-> dspIdle)
    else $error("DSP left idle outside run state");
  a_pdown_float: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    state == RBM_ST_PDOWN |-> pinOe_n && memDataOe_n && oscStop)
    else $error("Pins driven during power-down");
  a_dram_sel: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
    !ras_n |-> lowPageSelect_n && highPageSelect_n)
    else $error("Page select active during DRAM cycle");
  a_sram_sel: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
    !lowPageSelect_n || !highPageSelect_n |-> ras_n && cas_n && (lowPageSelect_n != highPageSelect_n))
    else $error("Bad select pattern on SRAM/ROM cycle");
  a_acc_len: assert property (@(posedge clk) disable iff (!rst_n || state == RBM_ST_PDOWN) // RULE1
    $rose(accBusy) |-> accBusy [*6] ##1 !accBusy)
    else $error("Memory access length not six cycles");

  c_boot_run: cover property (@(posedge clk) disable iff (!rst_n)
    state == RBM_ST_BOOT ##1 state == RBM_ST_RUN);
  c_pdown: cover property (@(posedge clk) disable iff (!rst_n) state == RBM_ST_PDOWN);
  c_dram_col: cover property (@(posedge clk) disable iff (!rst_n) !ras_n && !cas_n && accBusy);
  c_both_cpu: cover property (@(posedge clk) disable iff (!rst_n) cpuReq0 && cpuReq1 && cpuAck1);
endmodule : rbm_top

// *** verification/rbm_host_model.sv ***
`timescale 1ns/1ps
module rbm_host_model #(
  parameter logic [15:0] BASE = 16'hA000
) (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        burstReady,
  output logic             burstValid,
  output logic [15:0]      burstData,
  output logic             done
);
  int sent;
  // Word held until taken; released data shows its inverse
  always @(posedge clk) begin
    if (!go) begin
      burstValid <= 1'b0;
      burstData  <= ~BASE;
      sent       <= 0;
      done       <= 1'b0;
    end else if (burstValid && burstReady) begin
      sent       <= sent + 1;
      burstValid <= (sent < 255);
      burstData  <= (sent < 255) ? BASE + 16'(sent + 1) : ~burstData;
      done       <= (sent == 255);
    end else if (!burstValid && !done) begin
      burstValid <= 1'b1;
      burstData  <= BASE + 16'(sent);
    end
  end
endmodule : rbm_host_model

// *** verification/tb.sv ***
`timescale 1ns/1ps
module tb;
  import rbm_pkg::*;
  logic        clk, rst_n, refreshStrapPin, rowStrobeStrapPin, colStrobeStrapPin, powerDownPin_n;
  logic        psel, penable, pwrite, pready, pslverr, go;
  logic [1:0]  prevOe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        burstValid0, burstReady0, burstValid1, burstReady1, done0, done1;
  logic [15:0] burstData0, burstData1, cpuStartAddr, memDataOut;
  logic        cpuReq0, cpuAck0, cpuReq1, cpuAck1, cpuRun, bootRomSel, processorIndexBit0, processorIndexBit1;
  logic        dspIdle, oscStop, lowPageSelect_n, highPageSelect_n, ras_n, cas_n, memWe_n, pinOe_n, memDataOe_n;
  logic [27:0] cpuAddr0, cpuAddr1;
  logic [26:0] memoryAddressPins;
  int          miscompares, checked, writes, b;
  int          nxt[2];

  rbm_top dut_u (.clk(clk), .rst_n(rst_n), .refreshStrapPin(refreshStrapPin),
    .rowStrobeStrapPin(rowStrobeStrapPin), .colStrobeStrapPin(colStrobeStrapPin),
    .powerDownPin_n(powerDownPin_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .burstValid0(burstValid0),
    .burstData0(burstData0), .burstReady0(burstReady0), .burstValid1(burstValid1), .burstData1(burstData1),
    .burstReady1(burstReady1), .cpuReq0(cpuReq0), .cpuAddr0(cpuAddr0), .cpuAck0(cpuAck0), .cpuReq1(cpuReq1),
    .cpuAddr1(cpuAddr1), .cpuAck1(cpuAck1), .cpuRun(cpuRun), .cpuStartAddr(cpuStartAddr),
    .bootRomSel(bootRomSel), .processorIndexBit0(processorIndexBit0), .processorIndexBit1(processorIndexBit1),
    .dspIdle(dspIdle), .oscStop(oscStop), .memoryAddressPins(memoryAddressPins),
    .lowPageSelect_n(lowPageSelect_n), .highPageSelect_n(highPageSelect_n), .ras_n(ras_n), .cas_n(cas_n),
    .memWe_n(memWe_n), .memDataOut(memDataOut), .pinOe_n(pinOe_n), .memDataOe_n(memDataOe_n));
  rbm_host_model #(.BASE(16'hA000)) host0_u (.clk(clk), .go(go), .burstReady(burstReady0),
    .burstValid(burstValid0), .burstData(burstData0), .done(done0));
  rbm_host_model #(.BASE(16'h5000)) host1_u (.clk(clk), .go(go), .burstReady(burstReady1),
    .burstValid(burstValid1), .burstData(burstData1), .done(done1));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic do_reset(input logic [2:0] s);
    @(posedge clk);
    {refreshStrapPin, rowStrobeStrapPin, colStrobeStrapPin} <= s;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cpu_rd(input bit blk, input logic [27:0] a);
    int n;
    n = 0;
    @(posedge clk);
    if (blk) {cpuReq1, cpuAddr1} <= {1'b1, a};
    else {cpuReq0, cpuAddr0} <= {1'b1, a};
    @(posedge clk);
    while ((blk ? cpuAck1 : cpuAck0) !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    chk("cpu ack", 1, n < 50);
    cpuReq0 <= 1'b0;
    cpuReq1 <= 1'b0;
  endtask : cpu_rd

  function automatic logic [26:0] dmap(input logic [11:0] c);
    dmap = '0;
    dmap[8:0] = c[8:0];
    dmap[18] = c[9];
    dmap[20] = c[10];
    dmap[22] = c[11];
  endfunction : dmap

  task automatic t_straps();
    logic [31:0] q;
    logic        e;
    rbm_mem_e    hi[4] = '{RBM_MT_SRAM, RBM_MT_DRAM, RBM_MT_SDRAM, RBM_MT_ROM};
    for (int i = 0; i < 4; i++) begin
      do_reset({1'b0, 2'(i)});
      apb(1'b0, 12'h004, 32'h0, q, e);
      chk("straps", i, q[2:0]);
      chk("state", 3, q[5:3]);
      chk("low type", RBM_MT_ROM, q[9:8]);
      chk("high type", hi[i], q[11:10]);
      chk("start", 16'h0100, cpuStartAddr);
      chk("bootrom", 0, bootRomSel);
      chk("idle", 1, dspIdle);
    end
    apb(1'b1, 12'h000, 32'h0000_0005, q, e);
    apb(1'b0, 12'h004, 32'h0, q, e);
    chk("fw high type", RBM_MT_DRAM, q[11:10]);
    chk("dsp running", 0, dspIdle);
    apb(1'b0, 12'h008, 32'h0, q, e);
    chk("unmapped err", 1, e);
    chk("unmapped data", 0, q);
    chk("index0", 0, processorIndexBit0);
    chk("index1", 1, processorIndexBit1);
    $display("t_straps done");
  endtask : t_straps

  task automatic t_pages();
    logic [31:0] q;
    logic        e;
    logic [27:0] a;
    do_reset(3'b001);
    a = 28'h000_0246;
    cpu_rd(1'b0, a);
    chk("low sel", 0, lowPageSelect_n);
    chk("high sel", 1, highPageSelect_n);
    chk("ras cas", 2'b11, {ras_n, cas_n});
    chk("read we", 1, memWe_n);
    chk("read oe", 1, memDataOe_n);
    chk("rom pins", a[27:1], memoryAddressPins);
    a = 28'h800_1ABC;
    cpu_rd(1'b1, a);
    chk("dram sels", 2'b11, {lowPageSelect_n, highPageSelect_n});
    chk("dram strobes", 2'b00, {ras_n, cas_n});
    chk("col pins", dmap(a[12:1]), memoryAddressPins & dmap(12'hFFF));
    chk("shared run", 1, cpuRun);
    {refreshStrapPin, rowStrobeStrapPin, colStrobeStrapPin} <= 3'b110;
    repeat (4) @(posedge clk);
    apb(1'b0, 12'h004, 32'h0, q, e);
    chk("held straps", 3'b001, q[2:0]);
    $display("t_pages done");
  endtask : t_pages

  task automatic t_boot();
    logic [31:0] q;
    logic        e;
    logic        r;
    int          n;
    rbm_mem_e    lo[3] = '{RBM_MT_DRAM, RBM_MT_SDRAM, RBM_MT_SDRAM};
    for (int i = 0; i < 3; i++) begin
      do_reset(3'(5 + i));
      apb(1'b0, 12'h004, 32'h0, q, e);
      chk("boot low", lo[i], q[9:8]);
      chk("boot high", RBM_MT_ROM, q[11:10]);
    end
    do_reset(3'b100);
    n = 0;
    r = ras_n;
    repeat (24) begin
      @(posedge clk);
      if (ras_n !== r) n++;
      r = ras_n;
    end
    chk("sdram init", 1, n > 4);
    chk("bootrom", 1, bootRomSel);
    chk("boot start", 0, cpuStartAddr);
    nxt = '{0, 0};
    writes = 0;
    go <= 1'b1;
    n = 0;
    while (cpuStartAddr !== 16'h0100 && n < 20000) begin
      n++;
      @(posedge clk);
    end
    chk("resume addr", 16'h0100, cpuStartAddr);
    chk("host done", 2'b11, {done0, done1});
    chk("words", 512, writes);
    chk("resume", 0, bootRomSel);
    apb(1'b0, 12'h004, 32'h0, q, e);
    chk("done bits", 2'b11, q[7:6]);
    chk("boot types", {RBM_MT_ROM, RBM_MT_SRAM}, q[11:8]);
    chk("idle", 1, dspIdle);
    go <= 1'b0;
    $display("t_boot done");
  endtask : t_boot

  task automatic t_pdown();
    @(posedge clk);
    powerDownPin_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("osc stop", 1, oscStop);
    chk("float", 1, pinOe_n);
    powerDownPin_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("still down", 1, oscStop);
    do_reset(3'b000);
    chk("osc run", 0, oscStop);
    chk("pins on", 0, pinOe_n);
    $display("t_pdown done");
  endtask : t_pdown

  always @(posedge clk) begin
    // Pins follow the data enable one cycle later
    prevOe <= {prevOe[0], memDataOe_n};
    if (go && !memDataOe_n && !prevOe[0] && prevOe[1]) begin
      b = (memDataOut[15:12] == 4'h5);
      chk("boot data", (b ? 16'h5000 : 16'hA000) + nxt[b], memDataOut);
      chk("boot addr", 16'h0100 + nxt[b], memoryAddressPins);
      chk("boot sel", 0, lowPageSelect_n);
      nxt[b]++;
      writes++;
    end
  end

  initial begin
    #500_000;
    miscompares++;
    wrap_up();
  end

  initial begin
    rst_n = 1'b0;
    {refreshStrapPin, rowStrobeStrapPin, colStrobeStrapPin} = 3'b000;
    powerDownPin_n = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {cpuReq0, cpuReq1, cpuAddr0, cpuAddr1} = '0;
    go = 1'b0;
    t_straps();
    t_pages();
    t_boot();
    t_pdown();
    wrap_up();
  end
endmodule : tb
